// ===== logic/reset_and_watchdog_unit.sv
/*
  Reset controller with a watchdog timer: gathers reset sources,
  stretches the internal reset, enables the bandgap and runs the
  watchdog with its timed change sequence.
  Assumes all inputs synchronous to ref_clk except the reset path,
  which is combinational, and the oscillator input, synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none

module reset_and_watchdog_unit
  import reset_watchdog_pkg::*;
#(
  parameter int SHORT_DELAY_CYCLES = SHORT_DELAY_CYC,
  parameter int LONG_DELAY_CYCLES = LONG_DELAY_CYC
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regReadData,
  input wire logic powerOnDetect,
  input wire logic externalResetPinN,
  input wire logic brownoutDetect,
  input wire logic brownoutEnableFuse,
  input wire logic externalResetDisableFuse,
  input wire logic alwaysOnFuse,
  input wire logic [1:0] startupDelayFuse,
  input wire logic [3:0] clockSourceFuse,
  input wire logic comparatorBandgapSelect,
  input wire logic converterEnable,
  input wire logic watchdogOscIn,
  input wire logic watchdogRestart,
  input wire logic irqAck,
  output logic systemReset,
  output logic watchdogIrq,
  output logic bandgapEnable
);

  // ------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------
  if (SHORT_DELAY_CYCLES < 1 ||
      LONG_DELAY_CYCLES + OSC_SETTLE_CYC >= (1 << DELAY_W))
  begin : g_delay_check
    $error("startup delay does not fit the delay counter");
  end

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  // oscillator ticks to expiry, prescale clamped to the top setting
  function automatic logic [WD_CNT_W-1:0] timeoutTicks(
    input logic [3:0] prescale
  );
    logic [3:0] p;
    p = (prescale > PRESCALE_MAX) ? PRESCALE_MAX : prescale;
    timeoutTicks = WD_CNT_W'(WDT_BASE_TICKS) << p;
  endfunction

  // delay length from start-up and clock source fuses
  function automatic logic [DELAY_W-1:0] startupCycles(
    input logic [1:0] startup_delay_fuse,
    input logic [3:0] cks
  );
    logic [DELAY_W-1:0] base;
    case (startup_delay_fuse)
      2'h0: base = DELAY_W'(1);
      2'h1: base = DELAY_W'(SHORT_DELAY_CYCLES);
      default: base = DELAY_W'(LONG_DELAY_CYCLES);
    endcase
    // crystal sources need extra settling time
    if (cks[3]) begin
      base = base + DELAY_W'(OSC_SETTLE_CYC);
    end
    startupCycles = base;
  endfunction

  // operating mode from the effective enable bits
  function automatic watchdog_mode_type modeOf(
    input logic re,
    input logic ie
  );
    case ({re, ie})
      2'b01: modeOf = WD_INTERRUPT;
      2'b10: modeOf = WD_RESET;
      2'b11: modeOf = WD_COMBINED;
      default: modeOf = WD_STOPPED;
    endcase
  endfunction

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  watchdog_control_type ctrl_reg;
  reset_cause_type cause_reg;
  change_window_type window_reg;
  logic [2:0] windowCount_reg;
  logic [WD_CNT_W-1:0] wdCount_reg;
  logic oscMeta_reg;
  logic oscSync_reg;
  logic oscPrev_reg;
  logic wdPulse_reg;
  logic [7:0] readData_reg;
  logic bandgap_reg;
  logic externalActive;
  logic brownoutActive;
  logic anySource;
  logic holdReset;
  logic internalRst;
  logic oscTick;
  logic resetEnableEff;
  logic intEnableEff;
  watchdog_mode_type mode;
  logic [3:0] prescale;
  logic [WD_CNT_W-1:0] limit;
  logic expire;
  logic irqSet;
  logic resetReq;
  logic ctrlWrite;
  logic causeWrite;
  watchdog_control_type wrCtrl;
  reset_cause_type wrCause;
  logic openWrite;
  logic changeWrite;

  // ------------------------------------------------------------
  // reset sources
  // ------------------------------------------------------------
  // external pin only counts when its disable fuse is clear
  assign externalActive = ~externalResetPinN &
                          ~externalResetDisableFuse;
  assign brownoutActive = brownoutDetect &
                          brownoutEnableFuse;

  // purely combinational so it acts with no clock running
  assign anySource = reset | powerOnDetect | externalActive |
                     brownoutActive | wdPulse_reg;

  // ------------------------------------------------------------
  // reset stretching
  // ------------------------------------------------------------
  startup_delay_counter #(
    .CNT_W(DELAY_W)
  ) u_delay (
    .ref_clk(ref_clk),
    .sourceActive(anySource),
    .loadCycles(startupCycles(startupDelayFuse, clockSourceFuse)),
    .holdReset(holdReset)
  );

  // assert at once, release on the delay counter's clock edge
  assign internalRst = anySource | holdReset;
  assign systemReset = internalRst;

  // ------------------------------------------------------------
  // watchdog oscillator synchroniser
  // ------------------------------------------------------------
  // two flops, then an edge detector on the second
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      oscMeta_reg <= 1'b0;
      oscSync_reg <= 1'b0;
      oscPrev_reg <= 1'b0;
    end else begin
      oscMeta_reg <= watchdogOscIn;
      oscSync_reg <= oscMeta_reg;
      oscPrev_reg <= oscSync_reg;
    end
  end

  assign oscTick = oscSync_reg & ~oscPrev_reg;

  // ------------------------------------------------------------
  // effective configuration
  // ------------------------------------------------------------
  // fuse and reset flag override the stored bits
  assign resetEnableEff = ctrl_reg.resetEnable | alwaysOnFuse |
                          cause_reg.watchdogFlag;
  assign intEnableEff = ctrl_reg.intEnable & ~alwaysOnFuse;
  assign mode = modeOf(resetEnableEff, intEnableEff);
  assign prescale = {ctrl_reg.prescaleHigh, ctrl_reg.prescaleLow};
  assign limit = timeoutTicks(prescale);

  // ------------------------------------------------------------
  // watchdog counter
  // ------------------------------------------------------------
  // no sleep input: counting never pauses while enabled
  assign expire = oscTick && (mode != WD_STOPPED) &&
                  (wdCount_reg == limit - 1'b1);

  always_ff @(posedge ref_clk) begin
    if (internalRst || watchdogRestart || mode == WD_STOPPED) begin
      wdCount_reg <= '0;
    end else if (expire) begin
      wdCount_reg <= '0;
    end else if (oscTick) begin
      wdCount_reg <= wdCount_reg + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // time-out actions
  // ------------------------------------------------------------
  // combined mode resets only if the first interrupt is still pending
  assign irqSet = expire & intEnableEff;
  assign resetReq = expire & resetEnableEff &
                    (~intEnableEff | ctrl_reg.intFlag);

  // one-cycle reset pulse; the delay reloads until it falls
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wdPulse_reg <= 1'b0;
    end else begin
      wdPulse_reg <= resetReq & ~wdPulse_reg;
    end
  end

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  assign ctrlWrite = regWrite && regAddr == CONTROL_OFFSET;
  assign causeWrite = regWrite && regAddr == CAUSE_OFFSET;
  assign wrCtrl = watchdog_control_type'(regWriteData);
  assign wrCause = reset_cause_type'(regWriteData);
  assign openWrite = ctrlWrite & wrCtrl.changeEnable &
                     wrCtrl.resetEnable;
  assign changeWrite = ctrlWrite & ~wrCtrl.changeEnable &
                       (window_reg == WIN_OPEN);

  // ------------------------------------------------------------
  // change window
  // ------------------------------------------------------------
  // opens on the opening write, closes after four cycles or a change
  always_ff @(posedge ref_clk) begin
    if (internalRst) begin
      window_reg <= WIN_CLOSED;
      windowCount_reg <= 3'h0;
    end else begin
      case (window_reg)
        WIN_CLOSED: begin
          if (openWrite) begin
            window_reg <= WIN_OPEN;
            windowCount_reg <= CHANGE_WINDOW_CYCLES;
          end
        end
        WIN_OPEN: begin
          if (openWrite) begin
            windowCount_reg <= CHANGE_WINDOW_CYCLES;
          end else if (changeWrite || windowCount_reg == 3'h1) begin
            window_reg <= WIN_CLOSED;
            windowCount_reg <= 3'h0;
          end else begin
            windowCount_reg <= windowCount_reg - 3'h1;
          end
        end
        default: begin
          window_reg <= WIN_CLOSED;
          windowCount_reg <= 3'h0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // watchdog control register
  // ------------------------------------------------------------
  // reset enable: set freely, clear in window; prescale: change in window only
  always_ff @(posedge ref_clk) begin
    if (internalRst) begin
      ctrl_reg.resetEnable <= CONTROL_RESET[RE_POS];
      ctrl_reg.prescaleHigh <= CONTROL_RESET[PRESCALE_HIGH_POS];
      ctrl_reg.prescaleLow <= CONTROL_RESET[2:0];
    end else if (changeWrite) begin
      ctrl_reg.resetEnable <= wrCtrl.resetEnable;
      ctrl_reg.prescaleHigh <= wrCtrl.prescaleHigh;
      ctrl_reg.prescaleLow <= wrCtrl.prescaleLow;
    end else if (ctrlWrite && wrCtrl.resetEnable) begin
      ctrl_reg.resetEnable <= 1'b1;
    end
  end

  // change enable mirrors the open window
  always_ff @(posedge ref_clk) begin
    if (internalRst) begin
      ctrl_reg.changeEnable <= CONTROL_RESET[CE_POS];
    end else if (openWrite) begin
      ctrl_reg.changeEnable <= 1'b1;
    end else if (changeWrite || windowCount_reg == 3'h1) begin
      ctrl_reg.changeEnable <= 1'b0;
    end
  end

  // interrupt enable: vector in combined mode drops to reset mode
  always_ff @(posedge ref_clk) begin
    if (internalRst) begin
      ctrl_reg.intEnable <= CONTROL_RESET[IE_POS];
    end else if (irqAck && mode == WD_COMBINED) begin
      ctrl_reg.intEnable <= 1'b0;
    end else if (ctrlWrite) begin
      ctrl_reg.intEnable <= wrCtrl.intEnable;
    end
  end

  // interrupt flag: expiry wins over vector or write-one clear
  always_ff @(posedge ref_clk) begin
    if (internalRst) begin
      ctrl_reg.intFlag <= CONTROL_RESET[FLAG_POS];
    end else if (irqSet) begin
      ctrl_reg.intFlag <= 1'b1;
    end else if (irqAck || (ctrlWrite && wrCtrl.intFlag)) begin
      ctrl_reg.intFlag <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // reset cause register
  // ------------------------------------------------------------
  // survives internal resets except the reset input, which clears it; power-on clears the other causes
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cause_reg <= reset_cause_type'(CAUSE_RESET);
    end else if (powerOnDetect) begin
      cause_reg <= reset_cause_type'(CAUSE_RESET);
      cause_reg.powerOnFlag <= 1'b1;
    end else begin
      cause_reg.unused <= 4'h0;
      cause_reg.powerOnFlag <= cause_reg.powerOnFlag &
                               ~(causeWrite & ~wrCause.powerOnFlag);
      cause_reg.externalFlag <= externalActive |
        (cause_reg.externalFlag & ~(causeWrite & ~wrCause.externalFlag));
      cause_reg.brownoutFlag <= brownoutActive |
        (cause_reg.brownoutFlag & ~(causeWrite & ~wrCause.brownoutFlag));
      cause_reg.watchdogFlag <= wdPulse_reg |
        (cause_reg.watchdogFlag &
         ~(causeWrite & ~wrCause.watchdogFlag));
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  // data stands the cycle after the read strobe only
  always_ff @(posedge ref_clk) begin
    if (internalRst || !regRead) begin
      readData_reg <= READ_IDLE;
    end else begin
      case (regAddr)
        CONTROL_OFFSET: begin
          readData_reg <= {ctrl_reg.intFlag, intEnableEff,
                           ctrl_reg.prescaleHigh, ctrl_reg.changeEnable,
                           resetEnableEff, ctrl_reg.prescaleLow};
        end
        CAUSE_OFFSET: begin
          readData_reg <= cause_reg;
        end
        default: begin
          readData_reg <= READ_IDLE;
        end
      endcase
    end
  end

  assign regReadData = readData_reg;

  // ------------------------------------------------------------
  // bandgap and interrupt outputs
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bandgap_reg <= 1'b0;
    end else begin
      bandgap_reg <= brownoutEnableFuse | comparatorBandgapSelect |
                     converterEnable;
    end
  end

  assign bandgapEnable = bandgap_reg;

  // level request, also usable as a wake-up source
  assign watchdogIrq = ctrl_reg.intFlag & intEnableEff;

endmodule

`default_nettype wire

// ===== logic/reset_watchdog_pkg.sv
/*
  Shared constants, register layouts and types for the reset and
  watchdog unit.
  Assumes a 10 MHz system clock and a 128 kHz watchdog oscillator.
*/
`default_nettype none

package reset_watchdog_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] CAUSE_OFFSET = 8'h54;
  localparam logic [7:0] CONTROL_OFFSET = 8'h60;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CAUSE_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // field positions of the control register
  localparam int FLAG_POS = 7;
  localparam int IE_POS = 6;
  localparam int PRESCALE_HIGH_POS = 5;
  localparam int CE_POS = 4;
  localparam int RE_POS = 3;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int WDT_OSC_HZ = 128_000;
  localparam int WDT_BASE_TICKS = 2048;
  localparam int MIN_TIMEOUT_MS = 16;
  localparam int MAX_TIMEOUT_MS = 8000;
  localparam logic [3:0] PRESCALE_MAX = 4'h9;
  localparam int WD_CNT_W = 21;
  localparam logic [2:0] CHANGE_WINDOW_CYCLES = 3'h4;
  localparam int TOUT_SHORT_US = 4100;
  localparam int TOUT_LONG_US = 65000;
  localparam int OSC_SETTLE_US = 100;
  localparam int SHORT_DELAY_CYC = TOUT_SHORT_US * CLK_PER_US;
  localparam int LONG_DELAY_CYC = TOUT_LONG_US * CLK_PER_US;
  localparam int OSC_SETTLE_CYC = OSC_SETTLE_US * CLK_PER_US;
  localparam int DELAY_W = 20;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic intFlag;
    logic intEnable;
    logic prescaleHigh;
    logic changeEnable;
    logic resetEnable;
    logic [2:0] prescaleLow;
  } watchdog_control_type;

  typedef struct packed {
    logic [3:0] unused;
    logic watchdogFlag;
    logic brownoutFlag;
    logic externalFlag;
    logic powerOnFlag;
  } reset_cause_type;

  typedef enum {WD_STOPPED, WD_INTERRUPT, WD_RESET, WD_COMBINED}
    watchdog_mode_type;

  typedef enum {WIN_CLOSED, WIN_OPEN} change_window_type;

endpackage

`default_nettype wire

// ===== logic/startup_delay_counter.sv
/*
  Delay counter that stretches the internal reset after every
  reset source has gone inactive.
  Assumes the load value is steady while sources are active.
*/
`timescale 1ns/1ps
`default_nettype none

module startup_delay_counter
  import reset_watchdog_pkg::*;
#(
  parameter int CNT_W = DELAY_W
) (
  input wire logic ref_clk,
  input wire logic sourceActive,
  input wire logic [CNT_W-1:0] loadCycles,
  output logic holdReset
);

  // ------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------
  if (CNT_W < 2) begin : g_width_check
    $error("delay counter width too small");
  end

  logic [CNT_W-1:0] count_reg;
  logic hold_reg;

  // ------------------------------------------------------------
  // stretch counter
  // ------------------------------------------------------------
  // reload while any source is active, count down after
  always_ff @(posedge ref_clk) begin
    if (sourceActive) begin
      count_reg <= loadCycles;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  // release only at the clock edge after the count runs out
  always_ff @(posedge ref_clk) begin
    if (sourceActive) begin
      hold_reg <= 1'b1;
    end else if (count_reg == '0) begin
      hold_reg <= 1'b0;
    end
  end

  assign holdReset = hold_reg;

endmodule

`default_nettype wire

// ===== tb/core_side_model.sv
/* core-side model: watchdog oscillator, restarts, vector acknowledge
   assumes the bench raises serviceOn and ackOn after clock edges */
`timescale 1ns/1ps
`default_nettype none
module core_side_model #(
  parameter int OSC_HALF_NS = 350,
  parameter int RESTART_GAP = 5000
) (
  input wire logic ref_clk,
  input wire logic watchdogIrq,
  input wire logic serviceOn,
  input wire logic ackOn,
  output logic watchdogOscIn,
  output logic watchdogRestart,
  output logic irqAck
);
  int gapCnt = 0;
  // free-running oscillator, sped up to keep runs short
  initial begin
    watchdogOscIn = 1'b0;
    #13;
    forever #(OSC_HALF_NS) watchdogOscIn = ~watchdogOscIn;
  end
  // restart well inside the shortest time-out
  always @(posedge ref_clk) begin
    gapCnt <= (gapCnt == 0) ? RESTART_GAP : gapCnt - 1;
    watchdogRestart <= serviceOn && gapCnt == 0;
  end
  // vector execution acknowledges a pending interrupt once
  always @(posedge ref_clk) begin
    irqAck <= ackOn && watchdogIrq && !irqAck;
  end
endmodule
`default_nettype wire

// ===== tb/reset_and_watchdog_unit_chk.sv
/* checker for the reset and watchdog unit
   sees only the top module's ports, one clock domain */
`timescale 1ns/1ps
`default_nettype none
module reset_and_watchdog_unit_chk
  import reset_watchdog_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regReadData,
  input wire logic powerOnDetect,
  input wire logic externalResetPinN,
  input wire logic brownoutDetect,
  input wire logic brownoutEnableFuse,
  input wire logic externalResetDisableFuse,
  input wire logic alwaysOnFuse,
  input wire logic comparatorBandgapSelect,
  input wire logic converterEnable,
  input wire logic irqAck,
  input wire logic systemReset,
  input wire logic watchdogIrq,
  input wire logic bandgapEnable
);
  wire logic anySrc;
  wire logic bgWant;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // any visible source of reset
  assign anySrc = reset | powerOnDetect | (brownoutDetect & brownoutEnableFuse)
    | (~externalResetPinN & ~externalResetDisableFuse);
  assign bgWant = brownoutEnableFuse | comparatorBandgapSelect | converterEnable;
  sequence openWrite;
    regWrite && regAddr == CONTROL_OFFSET && regWriteData[CE_POS]
      && regWriteData[RE_POS] && !systemReset;
  endsequence
  chk_por_now: assert property (powerOnDetect |-> systemReset)
    else $error("power-on drop did not assert reset");
  chk_pin_now: assert property (!externalResetPinN &&
    !externalResetDisableFuse |-> systemReset)
    else $error("pin low did not assert reset");
  chk_bod_now: assert property (brownoutDetect && brownoutEnableFuse
    |-> systemReset) else $error("brown-out did not assert reset");
  chk_stretch_held: assert property ($past(anySrc) |-> systemReset)
    else $error("reset released with no stretch");
  chk_release_gap: assert property ($fell(systemReset)
    |-> !$past(anySrc, 2)) else $error("reset released too soon");
  chk_bandgap_sum: assert property (!$past(reset)
    |-> bandgapEnable == $past(bgWant)) else $error("bandgap enable wrong");
  chk_irq_clear: assert property (irqAck && watchdogIrq |=> !watchdogIrq)
    else $error("acknowledge did not clear interrupt");
  chk_fuse_locks: assert property (alwaysOnFuse |-> !watchdogIrq)
    else $error("interrupt raised with fuse programmed");
  chk_ce_selfclear: assert property (openWrite ##1 !regWrite [*4]
    ##1 (regRead && regAddr == CONTROL_OFFSET) |=> !regReadData[CE_POS])
    else $error("change enable did not self-clear");
  cover property ($rose(watchdogIrq));
  cover property ($fell(systemReset));
  cover property (irqAck && watchdogIrq);
endmodule
bind reset_and_watchdog_unit reset_and_watchdog_unit_chk
  reset_and_watchdog_unit_chk_i (.ref_clk(ref_clk), .reset(reset),
  .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
  .regRead(regRead), .regReadData(regReadData),
  .powerOnDetect(powerOnDetect), .externalResetPinN(externalResetPinN),
  .brownoutDetect(brownoutDetect), .brownoutEnableFuse(brownoutEnableFuse),
  .externalResetDisableFuse(externalResetDisableFuse),
  .alwaysOnFuse(alwaysOnFuse), .converterEnable(converterEnable),
  .comparatorBandgapSelect(comparatorBandgapSelect), .irqAck(irqAck),
  .systemReset(systemReset), .watchdogIrq(watchdogIrq),
  .bandgapEnable(bandgapEnable));
`default_nettype wire

// ===== tb/test_reset_and_watchdog_unit.sv
/* self-checking bench for the reset and watchdog unit
   core model supplies oscillator, restarts and acknowledge */
`timescale 1ns/1ps
`default_nettype none
module test_reset_and_watchdog_unit
  import reset_watchdog_pkg::*;
;
  localparam int SHORT = 8;
  typedef struct packed {
    logic [6:0] stim;
    logic rst;
    logic [7:0] cause;
    logic bg;
  } row_type;
  // stim: pin low, brown-out, bod fuse, pin disable, power-on, comparator_bandgap_select, adc
  row_type rows [8] = '{'{7'h40, 1'h1, 8'h02, 1'h0},
    '{7'h48, 1'h0, 8'h00, 1'h0}, '{7'h30, 1'h1, 8'h04, 1'h0},
    '{7'h20, 1'h0, 8'h00, 1'h0}, '{7'h10, 1'h0, 8'h00, 1'h1},
    '{7'h02, 1'h0, 8'h00, 1'h1}, '{7'h01, 1'h0, 8'h00, 1'h1},
    '{7'h04, 1'h1, 8'h01, 1'h0}};
  logic ref_clk, reset, regWrite, regRead, powerOnDetect, externalResetPinN;
  logic brownoutDetect, brownoutEnableFuse, externalResetDisableFuse;
  logic alwaysOnFuse, comparatorBandgapSelect, converterEnable;
  logic serviceOn, ackOn;
  logic [7:0] regAddr, regWriteData;
  logic [1:0] startupDelayFuse;
  wire logic [7:0] regReadData;
  wire logic systemReset, watchdogIrq, bandgapEnable;
  wire logic watchdogOscIn, watchdogRestart, irqAck;
  int n_fail = 0;
  int samples_checked = 0;
  int n;
  reset_and_watchdog_unit #(.SHORT_DELAY_CYCLES(SHORT),
    .LONG_DELAY_CYCLES(20)) reset_and_watchdog_unit_i (
    .ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
    .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
    .regReadData(regReadData), .powerOnDetect(powerOnDetect),
    .externalResetPinN(externalResetPinN), .brownoutDetect(brownoutDetect),
    .brownoutEnableFuse(brownoutEnableFuse), .alwaysOnFuse(alwaysOnFuse),
    .externalResetDisableFuse(externalResetDisableFuse),
    .startupDelayFuse(startupDelayFuse), .clockSourceFuse(4'h0),
    .comparatorBandgapSelect(comparatorBandgapSelect),
    .converterEnable(converterEnable), .watchdogOscIn(watchdogOscIn),
    .watchdogRestart(watchdogRestart), .irqAck(irqAck),
    .systemReset(systemReset), .watchdogIrq(watchdogIrq),
    .bandgapEnable(bandgapEnable));
  core_side_model core_side_model_i (.ref_clk(ref_clk),
    .watchdogIrq(watchdogIrq), .serviceOn(serviceOn), .ackOn(ackOn),
    .watchdogOscIn(watchdogOscIn), .watchdogRestart(watchdogRestart),
    .irqAck(irqAck));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // one-cycle bus accesses, read data sampled the cycle after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1;
    check(regReadData, exp);
  endtask
  // bounded wait for reset (sel 0) or interrupt (sel 1) level
  task automatic waitLvl(input int sel, input logic lvl, input int bound);
    n = 0;
    while (((sel == 0) ? systemReset : watchdogIrq) !== lvl) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > bound) begin
        n_fail++;
        $display("Error %0t: wait ran out", $time);
        end_of_test();
      end
    end
  endtask
  initial begin
    {regWrite, regRead, powerOnDetect, brownoutDetect} = 4'h0;
    {brownoutEnableFuse, externalResetDisableFuse, alwaysOnFuse} = 3'h0;
    {comparatorBandgapSelect, converterEnable, serviceOn, ackOn} = 4'h0;
    {regAddr, regWriteData} = 16'h0000;
    startupDelayFuse = 2'h0;
    externalResetPinN = 1'b1;
    reset = 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    waitLvl(0, 1'b0, 40);
    rd(CONTROL_OFFSET, CONTROL_RESET);
    rd(CAUSE_OFFSET, CAUSE_RESET);
    // ------------------------------------------------------------
    // sources and bandgap rows
    // ------------------------------------------------------------
    foreach (rows[i]) begin
      @(posedge ref_clk);
      externalResetPinN <= ~rows[i].stim[6];
      {brownoutDetect, brownoutEnableFuse, externalResetDisableFuse,
        powerOnDetect, comparatorBandgapSelect, converterEnable}
        <= rows[i].stim[5:0];
      @(posedge ref_clk);
      #1;
      check({7'h00, systemReset}, {7'h00, rows[i].rst});
      @(posedge ref_clk);
      #1;
      if (!rows[i].rst) check({7'h00, bandgapEnable}, {7'h00, rows[i].bg});
      @(posedge ref_clk);
      externalResetPinN <= 1'b1;
      {brownoutDetect, brownoutEnableFuse, externalResetDisableFuse} <= 3'h0;
      {powerOnDetect, comparatorBandgapSelect, converterEnable} <= 3'h0;
      waitLvl(0, 1'b0, 40);
      rd(CAUSE_OFFSET, rows[i].cause);
      wr(CAUSE_OFFSET, 8'h00);
    end
    // ------------------------------------------------------------
    // awkward cases
    // ------------------------------------------------------------
    startupDelayFuse <= 2'h1;
    @(posedge ref_clk);
    externalResetPinN <= 1'b0;
    @(posedge ref_clk);
    externalResetPinN <= 1'b1;
    waitLvl(0, 1'b0, 40);
    check({7'h00, n >= SHORT && n <= SHORT + 4}, 8'h01);
    startupDelayFuse <= 2'h0;
    wr(CAUSE_OFFSET, 8'h00);
    wr(CONTROL_OFFSET, 8'h48);
    wr(CONTROL_OFFSET, 8'h41);
    rd(CONTROL_OFFSET, 8'h48);
    wr(CONTROL_OFFSET, 8'h18);
    rd(CONTROL_OFFSET, 8'h18);
    wr(CONTROL_OFFSET, 8'h18);
    wr(CONTROL_OFFSET, 8'h07);
    rd(CONTROL_OFFSET, 8'h07);
    wr(8'h55, 8'hFF);
    rd(8'h55, 8'h00);
    wr(CONTROL_OFFSET, 8'h18);
    repeat (3) @(posedge ref_clk);
    rd(CONTROL_OFFSET, 8'h0F);
    wr(CONTROL_OFFSET, 8'h08);
    rd(CONTROL_OFFSET, 8'h0F);
    wr(CONTROL_OFFSET, 8'h18);
    wr(CONTROL_OFFSET, 8'h08);
    serviceOn <= 1'b1;
    n = 0;
    repeat (16000) begin
      @(posedge ref_clk);
      #1;
      if (systemReset !== 1'b0) n++;
    end
    check({7'h00, n != 0}, 8'h00);
    wr(CONTROL_OFFSET, 8'h18);
    wr(CONTROL_OFFSET, 8'h40);
    serviceOn <= 1'b0;
    waitLvl(1, 1'b1, 16000);
    check({7'h00, systemReset}, 8'h00);
    wr(CONTROL_OFFSET, 8'hC0);
    rd(CONTROL_OFFSET, 8'h40);
    wr(CONTROL_OFFSET, 8'h48);
    waitLvl(1, 1'b1, 16000);
    @(posedge ref_clk);
    ackOn <= 1'b1;
    waitLvl(1, 1'b0, 5);
    @(posedge ref_clk);
    ackOn <= 1'b0;
    rd(CONTROL_OFFSET, 8'h08);
    waitLvl(0, 1'b1, 16000);
    waitLvl(0, 1'b0, 40);
    rd(CAUSE_OFFSET, 8'h08);
    wr(CONTROL_OFFSET, 8'h18);
    wr(CONTROL_OFFSET, 8'h00);
    rd(CONTROL_OFFSET, 8'h08);
    wr(CAUSE_OFFSET, 8'h00);
    wr(CONTROL_OFFSET, 8'h18);
    wr(CONTROL_OFFSET, 8'h00);
    rd(CONTROL_OFFSET, 8'h00);
    @(posedge ref_clk);
    alwaysOnFuse <= 1'b1;
    rd(CONTROL_OFFSET, 8'h08);
    end_of_test();
  end
endmodule
`default_nettype wire
